//--- rtl/ahb_reg_slave.sv
// Module: AHB-Lite slave front end, turns a transfer into one-cycle register strobes.
// Assumes single word transfers; always OKAY, one wait state only for a read right behind a write.
`timescale 1ns/1ns
module ahb_reg_slave
    import reset_config_pkg::*;
(
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    // Register strobes
    output logic                      wr_en,
    output logic                      rd_en,
    output logic [ADDR_BITS-1:0]      reg_addr,
    output logic [31:0]               wr_data
);
    logic                 wpend_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic                 take;
    logic                 rd_behind_wr;

    // A read meeting a pending write waits a cycle, so the write keeps its own address
    assign rd_behind_wr = wpend_reg && hsel && htrans[1] && !hwrite;
    assign take         = hsel && hready && htrans[1];

    // Address phase capture; read strobes in address phase for data next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_reg <= 1'b0;
            addr_reg  <= '0;
        end else begin
            wpend_reg <= take && hwrite;
            if (take) begin
                addr_reg <= haddr[ADDR_BITS-1:0];
            end
        end
    end

    assign rd_en     = take && !hwrite;
    assign wr_en     = wpend_reg;
    assign reg_addr  = rd_en ? haddr[ADDR_BITS-1:0] : addr_reg;
    assign wr_data   = hwdata;
    assign hreadyout = !rd_behind_wr;
    assign hresp     = 1'b0;
endmodule

//--- rtl/nv_port_if.sv
// Interface: read request and answer between the loader and its nonvolatile read port.
// Assumes one read in flight at a time; the answer pulses valid for one cycle.
`timescale 1ns/1ns
interface nv_port_if;
    logic        req;
    logic [17:0] addr;
    logic        valid;
    logic [7:0]  data;
    logic        dbl_fault;

    modport loader (output req, output addr, input valid, input data, input dbl_fault);
    modport port   (input req, input addr, output valid, output data, output dbl_fault);
endinterface

//--- rtl/nv_read_port.sv
// Module: nonvolatile read port adapter, one request in flight, answer registered.
// Assumes the array answers arr_ack with data after a request is held.
`timescale 1ns/1ns
module nv_read_port
    import reset_config_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Loader side
    nv_port_if.port          lp,
    // Array side
    output logic             arr_rd,
    output logic [17:0]      arr_addr,
    input  wire logic        arr_ack,
    input  wire logic [7:0]  arr_data,
    input  wire logic        arr_dbl_fault
);
    logic       busy_reg;
    logic [7:0] data_reg;
    logic       valid_reg;
    logic       fault_reg;

    // Request hold and answer capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg  <= 1'b0;
            valid_reg <= 1'b0;
            data_reg  <= 8'h00;
            fault_reg <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            if (!busy_reg && lp.req) begin
                busy_reg <= 1'b1;
            end else if (busy_reg && arr_ack) begin
                busy_reg  <= 1'b0;
                valid_reg <= 1'b1;
                data_reg  <= arr_data;
                fault_reg <= arr_dbl_fault;
            end
        end
    end

    assign arr_rd       = busy_reg;
    assign arr_addr     = lp.addr;
    assign lp.valid     = valid_reg;
    assign lp.data      = data_reg;
    assign lp.dbl_fault = fault_reg;
endmodule

//--- rtl/reset_config_loader.sv
// Top: reset-time configuration loader for the watchdog control register and nonvolatile guard.
// Assumes hresetn covers every reset source and the nonvolatile array sits behind nv_read_port.
`timescale 1ns/1ns
module reset_config_loader
    import reset_config_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Nonvolatile array
    output logic             arr_rd,
    output logic [17:0]      arr_addr,
    input  wire logic        arr_ack,
    input  wire logic [7:0]  arr_data,
    input  wire logic        arr_dbl_fault,
    output logic             nv_cmd_abort,
    input  wire logic        nv_cmd_busy,
    // System
    output logic             cpu_stall,
    output logic             prot_active,
    output logic             sec_active,
    output logic [2:0]       watchdog_rate_select,
    output logic             watchdog_window_enable,
    output logic             periodic_timer_clock_out,
    output logic             irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    nv_port_if nvp ();

    load_state_type          state_reg;
    logic [7:0]              watchdog_control_reg;
    logic [7:0]              flash_option_reg;
    logic                    fault_reg;
    logic                    abort_reg;
    logic [IRQ_BITS-1:0]     irq_status_reg;
    logic [IRQ_BITS-1:0]     irq_mask_reg;
    logic [IRQ_BITS-1:0]     irq_set;
    logic                    wr_en;
    logic                    rd_en;
    logic [ADDR_BITS-1:0]    reg_addr;
    logic [31:0]             wr_data;
    logic [31:0]             rdata_next;
    logic [31:0]             hrdata_reg;
    logic                    rd_status;
    logic [2:0]              stored_rate_bits;
    logic                    stored_window_bit;

    // Selects a register by byte offset
    function automatic logic hit(input logic [ADDR_BITS-1:0] a, input logic [ADDR_BITS-1:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------------------------------
    // Bus front end and read port
    // ----------------------------------------------------------------
    ahb_reg_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data)
    );

    nv_read_port u_nv (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .lp            (nvp.port),
        .arr_rd        (arr_rd),
        .arr_addr      (arr_addr),
        .arr_ack       (arr_ack),
        .arr_data      (arr_data),
        .arr_dbl_fault (arr_dbl_fault)
    );

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    // Reads the protection word, then the option byte, then releases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= LOAD_IDLE;
        end else begin
            unique case (state_reg)
                LOAD_IDLE:   state_reg <= LOAD_PROT;
                LOAD_PROT:   state_reg <= LOAD_WAIT_P;
                LOAD_WAIT_P: state_reg <= nvp.valid ? LOAD_OPT : LOAD_WAIT_P;
                LOAD_OPT:    state_reg <= LOAD_WAIT_O;
                LOAD_WAIT_O: state_reg <= nvp.valid ? LOAD_DONE : LOAD_WAIT_O;
                LOAD_DONE:   state_reg <= LOAD_DONE;
                default:     state_reg <= LOAD_IDLE;
            endcase
        end
    end

    // Read request and address follow the sequencer state
    assign nvp.req   = (state_reg == LOAD_PROT) || (state_reg == LOAD_OPT);
    assign nvp.addr  = (state_reg == LOAD_OPT || state_reg == LOAD_WAIT_O) ? OPTION_GLOBAL_ADDR
                                                                           : PROT_GLOBAL_ADDR;
    // Processor held until every load has landed
    assign cpu_stall = (state_reg != LOAD_DONE);

    // ----------------------------------------------------------------
    // Loaded option byte and fault capture
    // ----------------------------------------------------------------
    // Option byte copy and sticky double-fault flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_option_reg <= OPTION_RESET;
            fault_reg        <= 1'b0;
        end else if (nvp.valid) begin
            if (nvp.dbl_fault) begin
                fault_reg <= 1'b1;
            end
            if (state_reg == LOAD_WAIT_O) begin
                flash_option_reg <= nvp.data;
            end
        end
    end

    // Protection and security follow the fault flag
    assign prot_active = fault_reg;
    assign sec_active  = fault_reg;

    // Stored option fields as they arrive
    assign stored_rate_bits  = nvp.data[RATE_MSB:RATE_LSB];
    assign stored_window_bit = nvp.data[STORED_WIN];

    // ----------------------------------------------------------------
    // Watchdog control register
    // ----------------------------------------------------------------
    // Loaded inverted from the option byte; software may rewrite afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_control_reg <= WDOG_CTRL_RESET;
        end else if (state_reg == LOAD_WAIT_O && nvp.valid) begin
            watchdog_control_reg[RATE_MSB:RATE_LSB] <= ~stored_rate_bits;
            watchdog_control_reg[WINDOW_BIT]        <= ~stored_window_bit;
        end else if (wr_en && hit(reg_addr, WDOG_CTRL_OFFSET) && !cpu_stall) begin
            watchdog_control_reg[RATE_MSB:RATE_LSB] <= wr_data[RATE_MSB:RATE_LSB];
            watchdog_control_reg[WINDOW_BIT]        <= wr_data[WINDOW_BIT];
        end
    end

    // Watchdog outputs
    assign watchdog_rate_select   = watchdog_control_reg[RATE_MSB:RATE_LSB];
    assign watchdog_window_enable = watchdog_control_reg[WINDOW_BIT];

    // ----------------------------------------------------------------
    // Command abort on reset
    // ----------------------------------------------------------------
    // Abort is asserted directly by reset, so it is immediate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_reg <= 1'b1;
        end else if (!nv_cmd_busy) begin
            abort_reg <= 1'b0;
        end
    end

    assign nv_cmd_abort = abort_reg || !hresetn;

    // No RAM here is cleared by reset, periodic clock output absent
    assign periodic_timer_clock_out = 1'b0;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // Interrupt events and the status read strobe
    assign irq_set[IRQ_LOAD_DONE] = (state_reg == LOAD_WAIT_O) && nvp.valid;
    assign irq_set[IRQ_DBL_FAULT] = nvp.valid && nvp.dbl_fault;
    assign irq_set[IRQ_CMD_ABORT] = abort_reg && nv_cmd_busy;
    assign rd_status              = rd_en && hit(reg_addr, IRQ_STATUS_OFFSET);

    // Sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (rd_status ? '0 : irq_status_reg) | irq_set;
        end
    end

    // Mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= '0;
        end else if (wr_en && hit(reg_addr, IRQ_MASK_OFFSET)) begin
            irq_mask_reg <= wr_data[IRQ_BITS-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Register read decode
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(reg_addr, WDOG_CTRL_OFFSET)) begin
            rdata_next[7:0] = watchdog_control_reg & 8'h87;
        end else if (hit(reg_addr, OPTION_OFFSET)) begin
            rdata_next[7:0] = flash_option_reg;
        end else if (hit(reg_addr, LOAD_STATUS_OFFSET)) begin
            rdata_next[3:0] = {sec_active, prot_active, fault_reg, cpu_stall};
        end else if (hit(reg_addr, IRQ_STATUS_OFFSET)) begin
            rdata_next[IRQ_BITS-1:0] = irq_status_reg;
        end else if (hit(reg_addr, IRQ_MASK_OFFSET)) begin
            rdata_next[IRQ_BITS-1:0] = irq_mask_reg;
        end
    end

    // Read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata_reg <= rdata_next;
        end
    end

    assign hrdata = hrdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_stall_until_done;
        @(posedge hclk) disable iff (!hresetn)
        $fell(cpu_stall) |-> $past(state_reg == LOAD_WAIT_O && nvp.valid);
    endproperty
    a_stall_until_done: assert property (p_stall_until_done) else $error("stall dropped early");

    property p_rate_inverted;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == LOAD_WAIT_O && nvp.valid) |=> (watchdog_rate_select == ~$past(stored_rate_bits));
    endproperty
    a_rate_inverted: assert property (p_rate_inverted) else $error("rate not inverted");

    property p_window_inverted;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == LOAD_WAIT_O && nvp.valid) |=> (watchdog_window_enable != $past(stored_window_bit));
    endproperty
    a_window_inverted: assert property (p_window_inverted) else $error("window not inverted");

    property p_loaded_at_release;
        @(posedge hclk) disable iff (!hresetn)
        $fell(cpu_stall) |-> (watchdog_rate_select == ~$past(stored_rate_bits) &&
                              watchdog_window_enable != $past(stored_window_bit));
    endproperty
    a_loaded_at_release: assert property (p_loaded_at_release) else $error("load late");

    property p_fault_protects;
        @(posedge hclk) disable iff (!hresetn)
        (nvp.valid && nvp.dbl_fault) |=> (prot_active && sec_active);
    endproperty
    a_fault_protects: assert property (p_fault_protects) else $error("fault not protected");

    property p_option_addr;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == LOAD_OPT) |-> (nvp.req && nvp.addr == OPTION_GLOBAL_ADDR);
    endproperty
    a_option_addr: assert property (p_option_addr) else $error("wrong option address");

    property p_abort_held;
        @(posedge hclk) disable iff (!hresetn)
        (abort_reg && nv_cmd_busy) |=> nv_cmd_abort;
    endproperty
    a_abort_held: assert property (p_abort_held) else $error("abort dropped while busy");

    property p_no_clock_out;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> !periodic_timer_clock_out;
    endproperty
    a_no_clock_out: assert property (p_no_clock_out) else $error("clock out driven");

    property p_sequence_start;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == LOAD_IDLE) |=> (state_reg == LOAD_PROT) ##1 (state_reg == LOAD_WAIT_P);
    endproperty
    a_sequence_start: assert property (p_sequence_start) else $error("sequence start wrong");

    // Loader reads run only while the processor is held
    property p_read_in_stall;
        @(posedge hclk) disable iff (!hresetn)
        arr_rd |-> cpu_stall;
    endproperty
    a_read_in_stall: assert property (p_read_in_stall) else $error("read after release");

    property p_abort_release;
        @(posedge hclk) disable iff (!hresetn)
        (abort_reg && !nv_cmd_busy) |=> !nv_cmd_abort;
    endproperty
    a_abort_release: assert property (p_abort_release) else $error("abort held when idle");

    property p_stall_write_ignored;
        @(posedge hclk) disable iff (!hresetn)
        (cpu_stall && wr_en && !nvp.valid) |=> $stable(watchdog_control_reg);
    endproperty
    a_stall_write_ignored: assert property (p_stall_write_ignored) else $error("write during stall");

    property p_fault_sticky;
        @(posedge hclk) disable iff (!hresetn)
        fault_reg |=> fault_reg;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost");

    property p_option_kept;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == LOAD_DONE) |=> $stable(flash_option_reg);
    endproperty
    a_option_kept: assert property (p_option_kept) else $error("option copy changed");
endmodule

//--- rtl/reset_config_pkg.sv
// Package: register map, field layout and sequencing constants for the reset configuration loader.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit wide nonvolatile read port.
package reset_config_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] WDOG_CTRL_OFFSET   = 12'h03C;
    localparam logic [11:0] OPTION_OFFSET      = 12'h040;
    localparam logic [11:0] LOAD_STATUS_OFFSET = 12'h044;
    localparam logic [11:0] IRQ_STATUS_OFFSET  = 12'h048;
    localparam logic [11:0] IRQ_MASK_OFFSET    = 12'h04C;
    localparam int          ADDR_BITS          = 12;

    // ----------------------------------------------------------------
    // Nonvolatile addresses
    // ----------------------------------------------------------------
    localparam logic [17:0] OPTION_GLOBAL_ADDR = 18'h3FF0E;
    localparam logic [17:0] PROT_GLOBAL_ADDR   = 18'h3FF0C;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int RATE_LSB     = 0;
    localparam int RATE_MSB     = 2;
    localparam int WINDOW_BIT   = 7;
    localparam int STORED_WIN   = 3;

    localparam logic [7:0] WDOG_CTRL_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET    = 8'hFF;

    // Interrupt status bits
    localparam int IRQ_LOAD_DONE  = 0;
    localparam int IRQ_DBL_FAULT  = 1;
    localparam int IRQ_CMD_ABORT  = 2;
    localparam int IRQ_BITS       = 3;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LOAD_IDLE   = 3'b000,
        LOAD_PROT   = 3'b001,
        LOAD_WAIT_P = 3'b010,
        LOAD_OPT    = 3'b011,
        LOAD_WAIT_O = 3'b100,
        LOAD_DONE   = 3'b101
    } load_state_type;

endpackage

//--- tb/nv_array_model.sv
// Partner model: nonvolatile array that answers each loader read after a set delay.
// Assumes one read outstanding at a time, held on arr_rd until it is answered.
`timescale 1ns/1ns
module nv_array_model
    import reset_config_pkg::*;
(
    // Clock
    input  wire logic        hclk,
    // Read port
    input  wire logic        arr_rd,
    input  wire logic [17:0] arr_addr,
    output logic             arr_ack       = 1'b0,
    output logic [7:0]       arr_data      = 8'h00,
    output logic             arr_dbl_fault = 1'b0,
    // Bench controls
    input  wire logic [7:0]  opt_byte,
    input  wire logic [1:0]  fault_sel,
    input  wire logic [2:0]  delay
);
    logic [2:0]  cnt_reg  = 3'h0;
    logic        done_reg = 1'b0;
    logic [17:0] addr_reg = 18'h00000;

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    // Data and fault lines toggle every cycle outside an answer, so stale data cannot pass
    always @(posedge hclk) begin
        arr_ack       <= 1'b0;
        arr_data      <= ~arr_data;
        arr_dbl_fault <= ~arr_dbl_fault;
        addr_reg      <= arr_addr;
        if (!arr_rd || arr_addr != addr_reg) begin
            done_reg <= 1'b0;
            cnt_reg  <= 3'h0;
        end else if (!done_reg) begin
            if (cnt_reg == delay) begin
                arr_ack       <= 1'b1;
                arr_data      <= (arr_addr == OPTION_GLOBAL_ADDR) ? opt_byte : 8'hFF;
                arr_dbl_fault <= (arr_addr == OPTION_GLOBAL_ADDR) ? fault_sel[1] : fault_sel[0];
                done_reg      <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end
endmodule

//--- tb/tb_reset_config_loader.sv
// Testbench: reset loading, option decode, bus registers, interrupts and command abort.
// Assumes the array model answers the loader and this bench is the only bus master.
`timescale 1ns/1ns
module tb_reset_config_loader
    import reset_config_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, rd_dph, nv_cmd_busy, hreadyout, hresp, irq;
    logic        arr_rd, arr_ack, arr_dbl_fault, nv_cmd_abort, cpu_stall, prot_active, sec_active;
    logic        watchdog_window_enable, periodic_timer_clock_out;
    logic [1:0]  htrans, fault_sel;
    logic [2:0]  hsize, delay, watchdog_rate_select;
    logic [7:0]  opt_byte, arr_data, o;
    logic [17:0] arr_addr;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] exp_q[$];
    int          fails, samples_checked, seed, r;

    reset_config_loader i_reset_config_loader (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .arr_rd, .arr_addr, .arr_ack, .arr_data, .arr_dbl_fault, .nv_cmd_abort, .nv_cmd_busy,
        .cpu_stall, .prot_active, .sec_active, .watchdog_rate_select, .watchdog_window_enable,
        .periodic_timer_clock_out, .irq
    );
    nv_array_model i_nv_array_model (
        .hclk, .arr_rd, .arr_addr, .arr_ack, .arr_data, .arr_dbl_fault, .opt_byte, .fault_sel, .delay
    );

    // ------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compare each read result with the oldest expected note
    always @(posedge hclk) begin
        if (rd_dph === 1'b1 && hreadyout === 1'b1) begin
            chk(hresp, 1'b0);
            chk(hrdata, exp_q.pop_front());
        end
    end

    // Cut a hang short
    initial begin
        #100000;
        fails++;
        give_verdict;
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task tick;
        @(posedge hclk);
        #1;
    endtask

    // One single word transfer; a read leaves its expected value in the queue
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        if (!w) exp_q.push_back(e);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dph <= ~w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dph <= 1'b0;
    endtask

    // Reset with a given option byte, optionally writing the watchdog during the stall
    task automatic do_reset(input logic [7:0] ob, input logic [1:0] f, input logic b, input logic wr);
        int n;
        @(posedge hclk);
        r = $random(seed);
        hresetn     <= 1'b0;
        opt_byte    <= ob;
        fault_sel   <= f;
        nv_cmd_busy <= b;
        delay       <= r[2:0];
        repeat (5) tick;
        chk(cpu_stall, 1'b1);
        chk(nv_cmd_abort, 1'b1);
        chk({arr_rd, irq, watchdog_window_enable, watchdog_rate_select}, 32'h0);
        chk(periodic_timer_clock_out, 1'b0);
        @(posedge hclk);
        hresetn <= 1'b1;
        if (wr) bus(1'b1, WDOG_CTRL_OFFSET, {24'h0, ob[3], 4'hF, ob[2:0]}, 32'h0);
        n = 0;
        while (cpu_stall !== 1'b0 && n < 300) begin
            tick;
            n++;
        end
        chk(cpu_stall, 1'b0);
        if (!f[1]) chk({watchdog_window_enable, watchdog_rate_select}, {~ob[3], ~ob[2:0]});
        chk({prot_active, sec_active}, {2{|f}});
        chk(nv_cmd_abort, b);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        hresetn         = 1'b0;
        hsel            = 1'b0;
        hwrite          = 1'b0;
        htrans          = 2'b00;
        hsize           = 3'b010;
        haddr           = 32'h0;
        hwdata          = 32'h0;
        rd_dph          = 1'b0;
        nv_cmd_busy     = 1'b0;
        opt_byte        = 8'h00;
        fault_sel       = 2'b00;
        delay           = 3'h0;
        fails           = 0;
        samples_checked = 0;
        seed            = 24189;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // Every option code; odd ones also try a watchdog write during the stall
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            o = {r[7:4], i[3:0]};
            do_reset(o, 2'b00, 1'b0, i[0]);
            bus(1'b0, WDOG_CTRL_OFFSET, 32'h0, {24'h0, ~o[3], 4'h0, ~o[2:0]});
            bus(1'b0, OPTION_OFFSET, 32'h0, {24'h0, o});
        end
        // Watchdog writable after the stall, unused bits read zero
        r = $random(seed);
        bus(1'b1, WDOG_CTRL_OFFSET, r, 32'h0);
        bus(1'b0, WDOG_CTRL_OFFSET, 32'h0, {24'h0, r[7], 4'h0, r[2:0]});
        chk({watchdog_window_enable, watchdog_rate_select}, {r[7], r[2:0]});
        // Unmapped place reads zero and ignores writes
        bus(1'b1, 12'h080, 32'hFFFF_FFFF, 32'h0);
        bus(1'b0, 12'h080, 32'h0, 32'h0);
        // Interrupt: mask reset value, raise by unmasking, clear by status read
        bus(1'b0, IRQ_MASK_OFFSET, 32'h0, 32'h0);
        chk(irq, 1'b0);
        bus(1'b1, IRQ_MASK_OFFSET, 32'h7, 32'h0);
        repeat (2) tick;
        chk(irq, 1'b1);
        bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 32'h1);
        repeat (2) tick;
        chk(irq, 1'b0);
        bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 32'h0);
        // Double fault on either read
        for (int f = 1; f < 3; f++) begin
            do_reset(8'h0F, f[1:0], 1'b0, 1'b0);
            bus(1'b0, LOAD_STATUS_OFFSET, 32'h0, 32'hE);
            bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 32'h3);
        end
        // Reset while a program or erase command runs
        do_reset(8'hA5, 2'b00, 1'b1, 1'b0);
        @(posedge hclk);
        nv_cmd_busy <= 1'b0;
        repeat (2) tick;
        chk(nv_cmd_abort, 1'b0);
        bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 32'h5);
        give_verdict;
    end
endmodule
